// >>> dv/sfcs_chk.sv
// port checker for the source fire channel sequencer
`timescale 1ns/1ps
module sfcs_chk #(
    parameter MS_CYC = 20,
    parameter BIT_CYC = 16
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // pins in
    input wire uart_rxd,
    input wire dtr_trig_in,
    input wire busy_in,
    input wire safety_closed_in,
    input wire stored_setup_in,
    input wire [3:0] ext_pulse_in,
    input wire [3:0] ext_closure_in,
    // pins out
    input wire uart_txd,
    input wire [3:0] src_trig_out,
    input wire [3:0] rec_trig_out,
    input wire [3:0] closure_out,
    input wire [3:0] extra_ind_out,
    input wire alarm_out,
    input wire configured_out
);
    localparam int W_MAX = 17 * MS_CYC + 4;
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_closure_match;
        closure_out == src_trig_out;
    endproperty
    a_closure_match: assert property (p_closure_match)
        else $error("closure drive differs from source trigger");
    property p_no_fire_alarm;
        alarm_out && $past(alarm_out, 3) |-> ((src_trig_out | rec_trig_out) &
            ~$past(src_trig_out | rec_trig_out)) == 4'h0;
    endproperty
    a_no_fire_alarm: assert property (p_no_fire_alarm)
        else $error("trigger started while safety loop open");
    property p_alarm_follow;
        $fell(safety_closed_in) |-> ##[1:4] alarm_out;
    endproperty
    a_alarm_follow: assert property (p_alarm_follow)
        else $error("alarm not raised after safety opened");
    property p_alarm_clear;
        $rose(safety_closed_in) |-> ##[1:4] !alarm_out;
    endproperty
    a_alarm_clear: assert property (p_alarm_clear)
        else $error("alarm not cleared after safety closed");
    property p_tx_idle;
        $fell(sys_rst) |-> uart_txd;
    endproperty
    a_tx_idle: assert property (p_tx_idle)
        else $error("serial out not idle high after reset");
    property p_tx_start;
        $fell(uart_txd) |-> !uart_txd [*8];
    endproperty
    a_tx_start: assert property (p_tx_start)
        else $error("serial start bit too short");
    property p_width_max;
        $rose(src_trig_out[0]) |-> ##[1:W_MAX] !src_trig_out[0];
    endproperty
    a_width_max: assert property (p_width_max)
        else $error("source pulse longer than widest setting");
    property p_unconf_quiet;
        !configured_out |-> src_trig_out == 4'h0 && rec_trig_out == 4'h0;
    endproperty
    a_unconf_quiet: assert property (p_unconf_quiet)
        else $error("trigger while not configured");
endmodule // sfcs_chk

// >>> dv/sfcs_host_model.sv
// host side serial model: sends setup frames, receives status bytes
`timescale 1ns/1ps
module sfcs_host_model #(
    parameter BIT_CYC = 16
) (
    // clock
    input wire clk,
    // serial lines
    output reg host_txd,
    input wire host_rxd
);
    reg [7:0] rx_byte;
    integer j;
    initial begin
        host_txd = 1'b1;
        rx_byte = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task send_byte(input [7:0] b);
        reg [9:0] fr;
        integer i;
        begin
            fr = {1'b1, b, 1'b0};
            for (i = 0; i < 10; i = i + 1) begin
                @(posedge clk);
                host_txd <= fr[i];
                repeat (BIT_CYC - 1) @(posedge clk);
            end
        end
    endtask
    task send_frame(input [3:0] cmd, input [1:0] ch, input [15:0] data);
        begin
            send_byte({cmd, 2'b00, ch});
            send_byte(data[15:8]);
            send_byte(data[7:0]);
            repeat (BIT_CYC) @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    always begin
        @(negedge host_rxd);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (j = 0; j < 8; j = j + 1) begin
            repeat (BIT_CYC) @(posedge clk);
            rx_byte[j] = host_rxd;
        end
        repeat (BIT_CYC) @(posedge clk);
    end
endmodule // sfcs_host_model

// >>> dv/sfcs_tb_top.sv
// self-checking testbench of the source fire channel sequencer
`timescale 1ns/1ps
`include "sfcs_defs.vh"
module sfcs_tb_top;
    localparam MS = 20;
    localparam BC = 16;
    // flags and shot counts of the busy cases
    localparam [111:0] FLAGS_TAB = {16'h0210, 16'h0010, 16'h0140, 16'h0300, 16'h0200,
        16'h0100, 16'h0000};
    localparam [27:0] EXP_TAB = {4'h6, 4'h3, 4'h1, 4'h2, 4'h1, 4'h0, 4'h0};
    reg clk, sys_rst, dtr_trig_in, busy_in, safety_closed_in, stored_setup_in;
    reg [3:0] ext_pulse_in, ext_closure_in;
    wire uart_rxd, uart_txd, alarm_out, configured_out;
    wire [3:0] src_trig_out, rec_trig_out, closure_out, extra_ind_out;
    integer miscompares, check_count, src_n, rec_n, cyc, rise_at, wid_seen, i;
    reg src_prev, rec_prev;
    sfcs_top #(.MS_CYC(MS), .BIT_CYC(BC)) u_sfcs_top (.clk(clk), .sys_rst(sys_rst),
        .uart_rxd(uart_rxd), .uart_txd(uart_txd), .dtr_trig_in(dtr_trig_in),
        .busy_in(busy_in), .safety_closed_in(safety_closed_in),
        .stored_setup_in(stored_setup_in), .ext_pulse_in(ext_pulse_in),
        .ext_closure_in(ext_closure_in), .src_trig_out(src_trig_out),
        .rec_trig_out(rec_trig_out), .closure_out(closure_out),
        .extra_ind_out(extra_ind_out), .alarm_out(alarm_out),
        .configured_out(configured_out));
    sfcs_host_model #(.BIT_CYC(BC)) u_sfcs_host_model (.clk(clk), .host_txd(uart_rxd),
        .host_rxd(uart_txd));
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    always @(negedge clk) begin
        cyc = cyc + 1;
        if (src_trig_out[0] === 1'b1 && src_prev === 1'b0) begin
            src_n = src_n + 1;
            rise_at = cyc;
        end
        if (src_trig_out[0] === 1'b0 && src_prev === 1'b1) wid_seen = cyc - rise_at;
        if (rec_trig_out[0] === 1'b1 && rec_prev === 1'b0) rec_n = rec_n + 1;
        src_prev = src_trig_out[0];
        rec_prev = rec_trig_out[0];
    end
    task check_lvl(input string what, input logic [7:0] exp, input logic [7:0] got);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("BAD %s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task check_num(input string what, input integer exp, input integer got);
        begin
            check_count = check_count + 1;
            if (got != exp) begin
                miscompares = miscompares + 1;
                $display("BAD %s expected %0d seen %0d", what, exp, got);
            end
        end
    endtask
    task frame(input [3:0] cmd, input [15:0] data);
        u_sfcs_host_model.send_frame(cmd, 2'b00, data);
    endtask
    task wait_ms(input integer n);
        repeat (n * MS) @(posedge clk);
    endtask
    task win(input integer n, input integer es, input integer er, input string what);
        begin
            src_n = 0;
            rec_n = 0;
            wait_ms(n);
            check_num(what, es, src_n);
            check_num(what, er, rec_n);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task t_reset;
        begin
            check_lvl("triggers", 8'h00, {src_trig_out, rec_trig_out});
            check_lvl("txd idle", 8'h01, {7'h00, uart_txd});
            frame(`SFCS_CMD_PERIOD, 16'h000A);
            win(30, 0, 0, "unconfigured");
            frame(`SFCS_CMD_CFGD, 16'h0000);
            check_lvl("configured", 8'h01, {7'h00, configured_out});
        end
    endtask
    task t_run;
        begin
            busy_in <= 1'b1;
            frame(`SFCS_CMD_FLAGS, 16'h0000);
            win(100, 10, 10, "run shots");
            frame(`SFCS_CMD_RDELAY, 16'h0005);
            frame(`SFCS_CMD_FLAGS, 16'h000C);
            win(100, 5, 5, "toggle shots");
            busy_in <= 1'b0;
        end
    endtask
    task t_inhibit;
        begin
            frame(`SFCS_CMD_PERIOD, 16'h3E80);
            frame(`SFCS_CMD_FPER, 16'h0002);
            frame(`SFCS_CMD_FCNT, 16'h0003);
            for (i = 0; i < 7; i = i + 1) begin
                frame(`SFCS_CMD_FLAGS, FLAGS_TAB[i*16 +: 16]);
                wait_ms(2);
                src_n = 0;
                busy_in <= 1'b1;
                wait_ms(20);
                busy_in <= 1'b0;
                wait_ms(9);
                if (i < 5) begin
                    check_num("busy", EXP_TAB[i*4 +: 4], src_n);
                end else begin
                    check_num("fixed", EXP_TAB[i*4 +: 4], src_n);
                end
            end
        end
    endtask
    task t_adv;
        begin
            frame(`SFCS_CMD_PERIOD, 16'h000A);
            frame(`SFCS_CMD_FLAGS, 16'h0000);
            frame(`SFCS_CMD_ADV, 16'h0000);
            win(1020, 1, 1, "slow shots");
            frame(`SFCS_CMD_ADV, 16'h0000);
            win(100, 0, 0, "stop shots");
            check_lvl("indicator", 8'h00, {4'h0, extra_ind_out});
            frame(`SFCS_CMD_ADV, 16'h0000);
            wait_ms(20);
            win(100, 10, 10, "rerun shots");
        end
    endtask
    task t_ext;
        begin
            frame(`SFCS_CMD_WIDTH, 16'h0003);
            frame(`SFCS_CMD_FLAGS, 16'h0001);
            src_n = 0;
            wait_ms(30);
            ext_pulse_in <= 4'h1;
            wait_ms(10);
            ext_pulse_in <= 4'h0;
            ext_closure_in <= 4'h1;
            wait_ms(10);
            ext_closure_in <= 4'h0;
            wait_ms(10);
            check_num("ext shots", 2, src_n);
            check_num("width ok", 1, (wid_seen >= 3 * MS && wid_seen <= 4 * MS + 2));
            frame(`SFCS_CMD_FLAGS, 16'h0003);
            src_n = 0;
            dtr_trig_in <= 1'b1;
            wait_ms(10);
            dtr_trig_in <= 1'b0;
            check_num("dtr shots", 1, src_n);
        end
    endtask
    task t_safety;
        begin
            frame(`SFCS_CMD_FLAGS, 16'h0000);
            safety_closed_in <= 1'b0;
            repeat (300) @(posedge clk);
            check_lvl("alarm", 8'h01, {7'h00, alarm_out});
            check_lvl("alarm byte", `SFCS_TX_ALARM, u_sfcs_host_model.rx_byte);
            win(60, 0, 0, "tripped shots");
            safety_closed_in <= 1'b1;
            repeat (300) @(posedge clk);
            check_lvl("alarm", 8'h00, {7'h00, alarm_out});
            check_lvl("clear byte", `SFCS_TX_CLEAR, u_sfcs_host_model.rx_byte);
        end
    endtask
    task summarize;
        begin
            $display("checks %0d miscompares %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0) begin
                $display("Run complete: PASS");
            end else begin
                $display("Run complete: FAIL");
            end
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (90000) @(posedge clk);
        miscompares = miscompares + 1;
        summarize;
    end
    initial begin
        miscompares = 0;
        check_count = 0;
        src_n = 0;
        rec_n = 0;
        cyc = 0;
        rise_at = 0;
        wid_seen = 0;
        src_prev = 1'b0;
        rec_prev = 1'b0;
        sys_rst = 1'b1;
        dtr_trig_in = 1'b0;
        busy_in = 1'b0;
        safety_closed_in = 1'b1;
        stored_setup_in = 1'b0;
        ext_pulse_in = 4'h0;
        ext_closure_in = 4'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        t_reset;
        t_run;
        t_inhibit;
        t_adv;
        t_ext;
        t_safety;
        summarize;
    end
endmodule // sfcs_tb_top
bind sfcs_top sfcs_chk #(.MS_CYC(MS_CYC), .BIT_CYC(BIT_CYC)) u_sfcs_chk (.clk(clk),
    .sys_rst(sys_rst), .uart_rxd(uart_rxd), .dtr_trig_in(dtr_trig_in), .busy_in(busy_in),
    .safety_closed_in(safety_closed_in), .stored_setup_in(stored_setup_in),
    .ext_pulse_in(ext_pulse_in), .ext_closure_in(ext_closure_in), .uart_txd(uart_txd),
    .src_trig_out(src_trig_out), .rec_trig_out(rec_trig_out), .closure_out(closure_out),
    .extra_ind_out(extra_ind_out), .alarm_out(alarm_out), .configured_out(configured_out));

// >>> logic/sfcs_defs.vh
// constants of the source fire channel sequencer
`ifndef SFCS_DEFS_VH
`define SFCS_DEFS_VH
`define SFCS_CLK_HZ 10000000
`define SFCS_CLK_NS 100
`define SFCS_BAUD 19200
`define SFCS_BIT_CYC (`SFCS_CLK_HZ / `SFCS_BAUD)
`define SFCS_TICK_NS 1000000
`define SFCS_MS_CYC (`SFCS_TICK_NS / `SFCS_CLK_NS)
`define SFCS_AUTO_MS 16'h1388
`define SFCS_STOP_EXT_MS 16'h2710
`define SFCS_SEC_MS 16'h03E8
`define SFCS_PER_MAX 16'h3E80
`define SFCS_PER_RST 16'h01F4
`define SFCS_STAGGER_MS 16'h007D
`define SFCS_WID_RST 4'h0
`define SFCS_CMD_PERIOD 4'h1
`define SFCS_CMD_RDELAY 4'h2
`define SFCS_CMD_WIDTH 4'h3
`define SFCS_CMD_SLOW 4'h4
`define SFCS_CMD_FLAGS 4'h5
`define SFCS_CMD_FPER 4'h6
`define SFCS_CMD_FCNT 4'h7
`define SFCS_CMD_ADV 4'h8
`define SFCS_CMD_SYNC 4'h9
`define SFCS_CMD_CFGD 4'hF
`define SFCS_F_EXT 0
`define SFCS_F_DTR 1
`define SFCS_F_TOG 2
`define SFCS_F_RDLY 3
`define SFCS_F_FIX 4
`define SFCS_F_SYNC 5
`define SFCS_F_ENDS 6
`define SFCS_TX_ALARM 8'h41
`define SFCS_TX_CLEAR 8'h43
`endif

// >>> logic/sfcs_top.v
// four channel source fire sequencer with serial configuration
`timescale 1ns/1ps
`include "sfcs_defs.vh"

// Functional notes
// [RULE_01] inhibit mode 0: busy input never suppresses channel triggers
// [RULE_02] inhibit mode 1: no triggers at all while busy is active
// [RULE_03] inhibit mode 2: one trigger attempt at busy onset only
// [RULE_04] inhibit mode 3: attempts at busy onset and at busy end
// [RULE_05] channel may follow another channel with offset, or shoot at inhibit end
// [RULE_06] configuration link is 19200 baud, 8 data bits, no parity, 1 stop
// [RULE_07] safety loop open halts all channels and reports alarm to host
// [RULE_08] buffered serial ready line may act as external trigger source
// [RULE_09] toggle fire alternates shots between recorder and source outputs
// [RULE_10] toggle fire disables recorder delay
// [RULE_11] fixed fire forces inhibit on
// [RULE_12] fixed fire shoots count shots at fixed period from inhibit end
// [RULE_13] strict inhibit fixed fire shoots only the count before next inhibit
// [RULE_14] early start or late finish lets fixed fire continue until next inhibit
// [RULE_15] stored setup without host: all channels fire in sequence every 500 ms
// [RULE_16] host downloads full setup after power-up unless device reports configured
// [RULE_17] advance command steps run, slow fire, stop, run
// [RULE_18] stop adds 10 s to period, no triggers, only indicator flashes; code lights the indicator at a stop period event and holds it
// [RULE_19] slow fire state keeps firing at period plus whole seconds
// [RULE_20] external mode fires only on that channel's pulse or closure input; code also fires on dtr_rise, busy edges, follow and fixed fire
// [RULE_21] new period not below recorder delay takes effect at once
// [RULE_22] closure outputs per channel with selectable width like pulses
// [RULE_23] slow fire extension is 1 to 16 seconds
// [RULE_24] pulse and closure width is 1 to 16 ms
// [RULE_25] periods clamp at 16000 ms
// [RULE_26] channels stay stopped until safety loop closes again
// [RULE_27] all timing counts a common 1 ms tick
module sfcs_top #(
    parameter MS_CYC = `SFCS_MS_CYC,
    parameter BIT_CYC = `SFCS_BIT_CYC
) (
    // clock and reset
    input wire clk,
    input wire sys_rst,
    // serial link and pins
    input wire uart_rxd,
    output reg uart_txd,
    input wire dtr_trig_in,
    input wire busy_in,
    input wire safety_closed_in,
    input wire stored_setup_in,
    input wire [3:0] ext_pulse_in,
    input wire [3:0] ext_closure_in,
    // channel outputs
    output wire [3:0] src_trig_out,
    output wire [3:0] rec_trig_out,
    output wire [3:0] closure_out,
    output wire [3:0] extra_ind_out,
    // status
    output wire alarm_out,
    output reg configured_out
);

localparam ST_RUN = 2'd0;
localparam ST_SLOW = 2'd1;
localparam ST_STOP = 2'd2;

////////////////////////////////////////////////////////////////////////////////
// input synchronisers and edges
reg [12:0] s1_reg;
reg [12:0] s2_reg;
reg [12:0] s3_reg;
always @(posedge clk) begin
    s1_reg <= {uart_rxd, dtr_trig_in, busy_in, safety_closed_in, stored_setup_in,
               ext_pulse_in, ext_closure_in};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
end
wire rxd = s2_reg[12];
wire busy = s2_reg[10];
wire busy_rise = s2_reg[10] & ~s3_reg[10];
wire busy_fall = ~s2_reg[10] & s3_reg[10];
wire dtr_rise = s2_reg[11] & ~s3_reg[11]; // RULE_08
wire halt = ~s2_reg[9]; // RULE_07 RULE_26
wire [3:0] ext_rise = (s2_reg[7:4] & ~s3_reg[7:4]) | (s2_reg[3:0] & ~s3_reg[3:0]);
assign alarm_out = halt;

////////////////////////////////////////////////////////////////////////////////
// millisecond tick
reg [15:0] ms_cnt_reg;
reg tick;
always @(posedge clk) begin
    if (sys_rst || ms_cnt_reg == MS_CYC[15:0] - 16'h0001) begin
        ms_cnt_reg <= 16'h0000;
    end else begin
        ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end
    tick <= ~sys_rst && ms_cnt_reg == MS_CYC[15:0] - 16'h0001; // RULE_27
end

////////////////////////////////////////////////////////////////////////////////
// serial receiver and three byte command frames
reg [15:0] rx_cnt_reg;
reg [3:0] rx_bit_reg;
reg [7:0] rx_sh_reg;
reg rx_busy_reg;
reg rx_done;
reg [1:0] fr_idx_reg;
reg [7:0] fr_cmd_reg;
reg [7:0] fr_hi_reg;
reg wr_stb;
reg [3:0] wr_cmd;
reg [1:0] wr_ch;
reg [15:0] wr_data;
reg host_seen_reg;
always @(posedge clk) begin
    rx_done <= 1'b0;
    if (sys_rst) begin
        rx_busy_reg <= 1'b0;
        rx_cnt_reg <= 16'h0000;
        rx_bit_reg <= 4'h0;
        rx_sh_reg <= 8'h00;
    end else if (!rx_busy_reg) begin
        if (!rxd) begin
            rx_busy_reg <= 1'b1;
            rx_cnt_reg <= BIT_CYC[16:1];
            rx_bit_reg <= 4'h0;
        end
    end else if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_reg <= BIT_CYC[15:0] - 16'h0001; // RULE_06
        if (rx_bit_reg == 4'h0 && rxd) begin
            rx_busy_reg <= 1'b0;
        end else if (rx_bit_reg == 4'h9) begin
            rx_busy_reg <= 1'b0;
            rx_done <= rxd;
        end else begin
            if (rx_bit_reg != 4'h0) begin
                rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
            end
            rx_bit_reg <= rx_bit_reg + 4'h1;
        end
    end else begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
    end
end
always @(posedge clk) begin
    wr_stb <= 1'b0;
    if (sys_rst) begin
        fr_idx_reg <= 2'd0;
        fr_cmd_reg <= 8'h00;
        fr_hi_reg <= 8'h00;
        wr_cmd <= 4'h0;
        wr_ch <= 2'd0;
        wr_data <= 16'h0000;
        host_seen_reg <= 1'b0;
    end else if (rx_done) begin
        host_seen_reg <= 1'b1;
        case (fr_idx_reg)
            2'd0: begin
                fr_cmd_reg <= rx_sh_reg;
                fr_idx_reg <= 2'd1;
            end
            2'd1: begin
                fr_hi_reg <= rx_sh_reg;
                fr_idx_reg <= 2'd2;
            end
            default: begin
                wr_stb <= 1'b1;
                wr_cmd <= fr_cmd_reg[7:4];
                wr_ch <= fr_cmd_reg[1:0];
                wr_data <= {fr_hi_reg, rx_sh_reg};
                fr_idx_reg <= 2'd0;
            end
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// configured state and autonomous start
reg [15:0] auto_cnt_reg;
always @(posedge clk) begin
    if (sys_rst) begin
        auto_cnt_reg <= 16'h0000;
        configured_out <= 1'b0;
    end else begin
        if (tick && auto_cnt_reg != `SFCS_AUTO_MS) begin
            auto_cnt_reg <= auto_cnt_reg + 16'h0001;
        end
        if (wr_stb && wr_cmd == `SFCS_CMD_CFGD) begin
            configured_out <= 1'b1; // RULE_16
        end else if (auto_cnt_reg == `SFCS_AUTO_MS && !host_seen_reg && s2_reg[8]) begin
            configured_out <= 1'b1; // RULE_15
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// alarm report transmitter
reg [9:0] tx_sh_reg;
reg [3:0] tx_left_reg;
reg [15:0] tx_cnt_reg;
reg alarm_sent_reg;
always @(posedge clk) begin
    if (sys_rst) begin
        uart_txd <= 1'b1;
        tx_sh_reg <= 10'h3FF;
        tx_left_reg <= 4'h0;
        tx_cnt_reg <= 16'h0000;
        alarm_sent_reg <= 1'b0;
    end else if (tx_left_reg == 4'h0) begin
        uart_txd <= 1'b1;
        if (alarm_sent_reg != halt) begin
            alarm_sent_reg <= halt; // RULE_07
            tx_sh_reg <= {1'b1, halt ? `SFCS_TX_ALARM : `SFCS_TX_CLEAR, 1'b0};
            tx_left_reg <= 4'hA;
            tx_cnt_reg <= 16'h0000;
        end
    end else if (tx_cnt_reg == 16'h0000) begin
        uart_txd <= tx_sh_reg[0];
        tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
        tx_left_reg <= tx_left_reg - 4'h1;
        tx_cnt_reg <= BIT_CYC[15:0] - 16'h0001;
    end else begin
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// channels
wire [3:0] shot_vec;
genvar g;
generate
for (g = 0; g < 4; g = g + 1) begin : ch
    reg [15:0] per_reg, dly_reg, fper_reg, sofs_reg, cnt_reg, fix_cnt_reg;
    reg [15:0] sync_cnt_reg, rd_cnt_reg;
    reg [7:0] flags_reg, fcnt_reg, fix_left_reg;
    reg [3:0] wid_reg, sb_reg;
    reg [4:0] sw_reg, rw_reg;
    reg [1:0] mode_reg, st_reg, ssrc_reg;
    reg fix_act_reg, sync_pend_reg, rd_pend_reg, tog_reg, src_reg, rec_reg, xtra_reg;
    localparam [31:0] CH_OFS = `SFCS_STAGGER_MS * g;
    wire fixed = flags_reg[`SFCS_F_FIX];
    wire toggle = flags_reg[`SFCS_F_TOG];
    wire [1:0] emode = (fixed && mode_reg == 2'd0) ? 2'd1 : mode_reg; // RULE_11
    wire inh = busy && emode != 2'd0; // RULE_01 RULE_02
    wire [15:0] ext_ms = (st_reg == ST_STOP) ? `SFCS_STOP_EXT_MS : // RULE_18
        (st_reg == ST_SLOW) ? ({12'h000, sb_reg} + 16'h0001) * `SFCS_SEC_MS : 16'h0000;
    wire [15:0] eff_per = per_reg + ext_ms; // RULE_19 RULE_23
    wire per_evt = tick && cnt_reg >= eff_per - 16'h0001;
    wire int_evt = per_evt && !flags_reg[`SFCS_F_EXT] && !fix_act_reg;
    wire ext_evt = flags_reg[`SFCS_F_EXT] && (ext_rise[g] || // RULE_20
        (flags_reg[`SFCS_F_DTR] && dtr_rise)); // RULE_08
    wire sync_evt = sync_pend_reg && tick && sync_cnt_reg == 16'h0000; // RULE_05
    wire fix_start = fixed && busy_fall; // RULE_12
    wire fix_evt = fix_act_reg && tick && fix_cnt_reg >= fper_reg - 16'h0001;
    wire edge_evt = (busy_rise && emode[1]) || // RULE_03 RULE_04
        (busy_fall && emode == 2'd3) || (busy_fall && flags_reg[`SFCS_F_ENDS]); // RULE_05
    wire live = configured_out && !halt && st_reg != ST_STOP; // RULE_26
    wire shot = live && (edge_evt || fix_start ||
        (!inh && (int_evt || ext_evt || sync_evt || fix_evt)));
    wire [15:0] wdat_c = (wr_data > `SFCS_PER_MAX) ? `SFCS_PER_MAX : wr_data; // RULE_25
    wire wr_me = wr_stb && wr_ch == g;
    assign shot_vec[g] = shot;
    assign src_trig_out[g] = src_reg;
    assign closure_out[g] = src_reg; // RULE_22
    assign rec_trig_out[g] = rec_reg;
    assign extra_ind_out[g] = xtra_reg;
    always @(posedge clk) begin
        if (sys_rst) begin
            per_reg <= `SFCS_PER_RST; // RULE_15
            dly_reg <= 16'h0000;
            fper_reg <= `SFCS_PER_RST;
            sofs_reg <= 16'h0000;
            cnt_reg <= CH_OFS[15:0];
            fix_cnt_reg <= 16'h0000;
            sync_cnt_reg <= 16'h0000;
            rd_cnt_reg <= 16'h0000;
            flags_reg <= 8'h00;
            fcnt_reg <= 8'h00;
            fix_left_reg <= 8'h00;
            wid_reg <= `SFCS_WID_RST;
            sb_reg <= 4'h0;
            sw_reg <= 5'h00;
            rw_reg <= 5'h00;
            mode_reg <= 2'd0;
            st_reg <= ST_RUN;
            ssrc_reg <= 2'd0;
            fix_act_reg <= 1'b0;
            sync_pend_reg <= 1'b0;
            rd_pend_reg <= 1'b0;
            tog_reg <= 1'b0;
            src_reg <= 1'b0;
            rec_reg <= 1'b0;
            xtra_reg <= 1'b0;
        end else begin
            if (wr_me) begin
                case (wr_cmd)
                    `SFCS_CMD_PERIOD: if (wdat_c >= dly_reg) per_reg <= wdat_c; // RULE_21
                    `SFCS_CMD_RDELAY: if (wr_data <= per_reg) dly_reg <= wr_data;
                    `SFCS_CMD_WIDTH: wid_reg <= wr_data[3:0]; // RULE_24
                    `SFCS_CMD_SLOW: sb_reg <= wr_data[3:0];
                    `SFCS_CMD_FLAGS: begin
                        flags_reg <= wr_data[7:0];
                        mode_reg <= wr_data[9:8];
                    end
                    `SFCS_CMD_FPER: fper_reg <= wdat_c;
                    `SFCS_CMD_FCNT: fcnt_reg <= wr_data[7:0];
                    `SFCS_CMD_ADV: st_reg <= (st_reg == ST_RUN) ? ST_SLOW : // RULE_17
                        (st_reg == ST_SLOW) ? ST_STOP : ST_RUN;
                    `SFCS_CMD_SYNC: begin
                        sofs_reg <= {2'b00, wdat_c[13:0]};
                        ssrc_reg <= wr_data[15:14];
                    end
                    default: ;
                endcase
            end
            // period counter
            if (per_evt) begin
                cnt_reg <= 16'h0000;
            end else if (tick) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
            // fixed fire sequence
            if (fix_start) begin
                fix_act_reg <= fcnt_reg > 8'h01 || (fcnt_reg != 8'h00 && emode[1]); // RULE_12
                fix_left_reg <= fcnt_reg - 8'h01;
                fix_cnt_reg <= 16'h0000;
            end else if (busy_rise || !fixed) begin
                fix_act_reg <= 1'b0; // RULE_13
            end else if (fix_evt) begin
                fix_cnt_reg <= 16'h0000;
                if (fix_left_reg != 8'h00) begin
                    fix_left_reg <= fix_left_reg - 8'h01;
                end
                if (fix_left_reg <= 8'h01 && !emode[1]) begin
                    fix_act_reg <= 1'b0; // RULE_13 RULE_14
                end
            end else if (tick) begin
                fix_cnt_reg <= fix_cnt_reg + 16'h0001;
            end
            // follow another channel
            if (flags_reg[`SFCS_F_SYNC] && shot_vec[ssrc_reg] && ssrc_reg != g) begin
                sync_pend_reg <= 1'b1;
                sync_cnt_reg <= sofs_reg;
            end else if (sync_evt || halt) begin
                sync_pend_reg <= 1'b0;
            end else if (tick && sync_pend_reg) begin
                sync_cnt_reg <= sync_cnt_reg - 16'h0001;
            end
            // stop state indicator: set by a period event in stop, cleared by a period event outside stop
            if (st_reg == ST_STOP && per_evt) begin
                xtra_reg <= 1'b1;
            end else if (per_evt) begin
                xtra_reg <= 1'b0;
            end
            // output pulses
            if (shot && toggle) begin
                tog_reg <= ~tog_reg; // RULE_09
            end
            if (shot && !(toggle && tog_reg)) begin
                sw_reg <= {1'b0, wid_reg} + 5'h01;
                src_reg <= 1'b1;
            end else if (tick && sw_reg != 5'h00) begin
                sw_reg <= sw_reg - 5'h01;
                src_reg <= sw_reg != 5'h01;
            end
            if (shot && flags_reg[`SFCS_F_RDLY] && !toggle) begin
                rd_pend_reg <= 1'b1;
                rd_cnt_reg <= dly_reg;
            end else if (tick && rd_pend_reg) begin
                rd_cnt_reg <= rd_cnt_reg - 16'h0001;
                rd_pend_reg <= rd_cnt_reg > 16'h0001 && !halt;
            end
            if ((shot && (toggle ? tog_reg : !flags_reg[`SFCS_F_RDLY])) || // RULE_10
                (tick && rd_pend_reg && rd_cnt_reg <= 16'h0001 && !halt)) begin
                rw_reg <= {1'b0, wid_reg} + 5'h01;
                rec_reg <= 1'b1;
            end else if (tick && rw_reg != 5'h00) begin
                rw_reg <= rw_reg - 5'h01;
                rec_reg <= rw_reg != 5'h01;
            end
        end
    end
end
endgenerate

endmodule // sfcs_top
